// File: ddr_subsys_ctrl_regs.sv
// APB register bank for the fabric memory subsystem: resets, calibration, masks, status
// assumes pclk at 10 MHz, event and lock inputs asynchronous to pclk
// Behaviour
// - bus interface reset bit holds interface controller
// - controller reset bit zero holds whole subsystem
// - trim bit selects programmed codes over calibrated
// - freeze bit locks codes without self refresh
// - rerun bit restarts the calibration state machine
// - pull-down code bits 11:6, loadable, reset zero
// - pull-up code bits 5:0, loadable, writable
// - mask bits 6,5,4: bus, calibration, ecc
// - mask bits 3..0 gate four pll events
// - protocol select: one AXI, zero AHB default
// - auto-lock enable bit zero, resets disabled
// - fabric pll status bit zero shows lock
// - calibration completion raises calibration event
// - pll lock edges set lost and gained events
`timescale 1ns/1ps
`include "ddr_subsys_regs.svh"

module ddr_subsys_ctrl_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        pclken,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ADDR_W-1:0]           paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        nv_code_load,
   input  wire logic [5:0]                  nv_pulldown_code,
   input  wire logic [5:0]                  nv_pullup_code,
   input  wire logic                        subsystem_pll_locked,
   input  wire logic                        fabric_pll_locked,
   input  wire logic                        calibration_done_irq,
   input  wire logic                        ecc_error_event,
   input  wire logic                        bus_if_event,
   output logic                             memctl_reset_hold,
   output logic                             bus_if_reset_hold,
   output ddr_subsys_pkg::calib_ctrl_t      calib_ctrl,
   output logic                             fabric_axi_select,
   output logic                             auto_code_lock_enable,
   output logic                             subsys_irq
);
   import ddr_subsys_pkg::*;

   // ========================================================================
   // elaboration checks
   generate
      if (ADDR_W <= `OFF_W) begin : g_bad_addr
         $error("ADDR_W must exceed the register offset width");
      end
   endgenerate

   // ========================================================================
   // declarations
   raw_in_t              raw_in;
   raw_in_t              sync1;
   raw_in_t              sync2;
   raw_in_t              sync3;
   raw_in_t              level;
   raw_in_t              level_d;
   raw_in_t              rise;
   raw_in_t              fall;
   event_vec_t           irq_mask;
   event_vec_t           event_flags;
   event_vec_t           event_set;
   event_vec_t           event_clr;
   event_vec_t           next_event_flags;
   logic                 fab_pll_status;
   logic                 setup;
   logic                 access;
   logic                 wr_en;
   logic [`OFF_W-1:0]    offset;
   logic                 addr_hit;
   logic                 mapped;
   logic [31:0]          rd_word;

   assign raw_in[`IN_SUB_PLL] = subsystem_pll_locked;
   assign raw_in[`IN_FAB_PLL] = fabric_pll_locked;
   assign raw_in[`IN_CALIB]   = calibration_done_irq;
   assign raw_in[`IN_ECC]     = ecc_error_event;
   assign raw_in[`IN_BUS_IF]  = bus_if_event;

   // ========================================================================
   // input synchronisers
   // third stage lets a change count only once two stages agree,
   // filtering a single metastable resolution
   genvar gi;
   generate
      for (gi = 0; gi < `IN_W; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
            end else if (pclken) begin
               sync1[gi] <= raw_in[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               level[gi]   <= 1'b0;
               level_d[gi] <= 1'b0;
            end else if (pclken) begin
               if (sync2[gi] == sync3[gi]) begin
                  level[gi] <= sync3[gi];
               end
               level_d[gi] <= level[gi];
            end
         end

         assign rise[gi] = level[gi] & ~level_d[gi];
         assign fall[gi] = ~level[gi] & level_d[gi];
      end
   endgenerate

   // ========================================================================
   // event sources
   always_comb begin
      event_set                 = `RST_EVENTS;
      event_set[`EV_SUB_LOCK]   = rise[`IN_SUB_PLL];
      event_set[`EV_SUB_UNLOCK] = fall[`IN_SUB_PLL];
      event_set[`EV_FAB_LOCK]   = rise[`IN_FAB_PLL];
      event_set[`EV_FAB_UNLOCK] = fall[`IN_FAB_PLL];
      event_set[`EV_ECC]        = rise[`IN_ECC];
      event_set[`EV_CALIB]      = rise[`IN_CALIB];
      event_set[`EV_BUS_IF]     = rise[`IN_BUS_IF];
   end

   // ========================================================================
   // APB decode
   // no wait state: read data is captured in setup, writes land in the access cycle, pready is high in the first access cycle
   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready;
   assign offset   = {paddr[`OFF_W-1:2], 2'b00};
   assign addr_hit = (paddr[ADDR_W-1:`OFF_W] == '0);
   assign mapped   = addr_hit & (offset == `OFF_SOFT_RESET   ||
                                 offset == `OFF_IO_CALIB     ||
                                 offset == `OFF_IRQ_MASK     ||
                                 offset == `OFF_PROTOCOL_SEL ||
                                 offset == `OFF_AUTO_LOCK    ||
                                 offset == `OFF_FAB_PLL_STATUS ||
                                 offset == `OFF_EVENT_STATUS);
   // status register ignores writes but still answers without error
   assign wr_en    = access & pwrite & mapped & ~pslverr;

   always_comb begin
      rd_word = `RST_WORD;
      if (addr_hit) begin
         case (offset)
            `OFF_SOFT_RESET: begin
               rd_word[`BIT_MEMCTL_RESET] = memctl_reset_hold;
               rd_word[`BIT_BUS_IF_RESET] = bus_if_reset_hold;
            end
            `OFF_IO_CALIB: begin
               rd_word[`BIT_TRIM]           = calib_ctrl.code_trim_override;
               rd_word[`BIT_FREEZE]         = calib_ctrl.code_freeze_override;
               rd_word[`PD_HI:`PD_LO]       = calib_ctrl.pulldown_override_code;
               rd_word[`PU_HI:`PU_LO]       = calib_ctrl.pullup_override_code;
            end
            `OFF_IRQ_MASK: begin
               rd_word[`EV_W-1:0] = irq_mask;
            end
            `OFF_PROTOCOL_SEL: begin
               rd_word[`BIT_LSB] = fabric_axi_select;
            end
            `OFF_AUTO_LOCK: begin
               rd_word[`BIT_LSB] = auto_code_lock_enable;
            end
            `OFF_FAB_PLL_STATUS: begin
               rd_word[`BIT_LSB] = fab_pll_status;
            end
            `OFF_EVENT_STATUS: begin
               rd_word[`EV_W-1:0] = event_flags;
            end
            default: begin
               rd_word = `RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `RST_WORD;
      end else if (pclken) begin
         if (setup) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? `RST_WORD : rd_word;
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `RST_WORD;
         end
      end
   end

   // ========================================================================
   // soft resets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memctl_reset_hold <= `RST_HOLD;
         bus_if_reset_hold <= `RST_HOLD;
      end else if (pclken && wr_en && offset == `OFF_SOFT_RESET) begin
         memctl_reset_hold <= pwdata[`BIT_MEMCTL_RESET];
         bus_if_reset_hold <= pwdata[`BIT_BUS_IF_RESET];
      end
   end

   // ========================================================================
   // calibration control
   // rerun is a one-cycle request; the stored bit reads back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calib_ctrl.code_trim_override   <= `RST_BIT;
         calib_ctrl.code_freeze_override <= `RST_BIT;
         calib_ctrl.calibration_rerun    <= `RST_BIT;
      end else if (pclken) begin
         calib_ctrl.calibration_rerun <= 1'b0;
         if (wr_en && offset == `OFF_IO_CALIB) begin
            calib_ctrl.code_trim_override   <= pwdata[`BIT_TRIM];
            calib_ctrl.code_freeze_override <= pwdata[`BIT_FREEZE];
            calib_ctrl.calibration_rerun    <= pwdata[`BIT_RERUN];
         end
      end
   end

   // firmware write wins over a simultaneous non-volatile load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calib_ctrl.pulldown_override_code <= `RST_CODE;
         calib_ctrl.pullup_override_code   <= `RST_CODE;
      end else if (pclken) begin
         if (wr_en && offset == `OFF_IO_CALIB) begin
            calib_ctrl.pulldown_override_code <= pwdata[`PD_HI:`PD_LO];
            calib_ctrl.pullup_override_code   <= pwdata[`PU_HI:`PU_LO];
         end else if (nv_code_load) begin
            calib_ctrl.pulldown_override_code <= nv_pulldown_code;
            calib_ctrl.pullup_override_code   <= nv_pullup_code;
         end
      end
   end

   // ========================================================================
   // interrupt masks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `RST_EVENTS;
      end else if (pclken && wr_en && offset == `OFF_IRQ_MASK) begin
         irq_mask <= pwdata[`EV_W-1:0];
      end
   end

   // ========================================================================
   // mode bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fabric_axi_select     <= `RST_BIT;
         auto_code_lock_enable <= `RST_BIT;
      end else if (pclken && wr_en) begin
         if (offset == `OFF_PROTOCOL_SEL) begin
            fabric_axi_select <= pwdata[`BIT_LSB];
         end
         if (offset == `OFF_AUTO_LOCK) begin
            auto_code_lock_enable <= pwdata[`BIT_LSB];
         end
      end
   end

   // ========================================================================
   // fabric pll status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fab_pll_status <= `RST_BIT;
      end else if (pclken) begin
         fab_pll_status <= level[`IN_FAB_PLL];
      end
   end

   // ========================================================================
   // event flags, write one to clear; a new event beats its clear
   always_comb begin
      event_clr = `RST_EVENTS;
      if (wr_en && offset == `OFF_EVENT_STATUS) begin
         event_clr = pwdata[`EV_W-1:0];
      end
      next_event_flags = (event_flags & ~event_clr) | event_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_flags <= `RST_EVENTS;
      end else if (pclken) begin
         event_flags <= next_event_flags;
      end
   end

   // ========================================================================
   // combined interrupt, registered from the next flag state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         subsys_irq <= 1'b0;
      end else if (pclken) begin
         subsys_irq <= |(next_event_flags & irq_mask);
      end
   end
endmodule

// File: ddr_subsys_regs.svh
// bit positions, offsets and reset values of the memory subsystem control registers
// assumes inclusion by the package, the register bank, the checker and the bench
`ifndef DDR_SUBSYS_REGS_SVH
`define DDR_SUBSYS_REGS_SVH

// ==========================================================================
// register offsets (byte addresses, one aligned word each)
`define OFF_SOFT_RESET      5'h00
`define OFF_IO_CALIB        5'h04
`define OFF_IRQ_MASK        5'h08
`define OFF_PROTOCOL_SEL    5'h0C
`define OFF_AUTO_LOCK       5'h10
`define OFF_FAB_PLL_STATUS  5'h14
`define OFF_EVENT_STATUS    5'h18
`define OFF_W               5

// ==========================================================================
// soft reset fields
`define BIT_MEMCTL_RESET    0
`define BIT_BUS_IF_RESET    1
`define RST_HOLD            1'h1

// ==========================================================================
// calibration control fields
`define BIT_TRIM            14
`define BIT_FREEZE          13
`define BIT_RERUN           12
`define PD_HI               11
`define PD_LO               6
`define PU_HI               5
`define PU_LO               0
`define CODE_W              6
`define RST_CODE            6'h00

// ==========================================================================
// event and mask positions (status register uses the same layout)
`define EV_SUB_LOCK         0
`define EV_SUB_UNLOCK       1
`define EV_FAB_LOCK         2
`define EV_FAB_UNLOCK       3
`define EV_ECC              4
`define EV_CALIB            5
`define EV_BUS_IF           6
`define EV_W                7
`define RST_EVENTS          7'h00

// ==========================================================================
// single-bit registers and raw input positions
`define BIT_LSB             0
`define RST_BIT             1'h0
`define IN_SUB_PLL          0
`define IN_FAB_PLL          1
`define IN_CALIB            2
`define IN_ECC              3
`define IN_BUS_IF           4
`define IN_W                5
`define RST_IN              5'h00
`define RST_WORD            32'h0000_0000
`endif

// File: ddr_subsys_pkg.sv
// types shared by the memory subsystem register bank and its users
// assumes the constants header sits in the same folder
package ddr_subsys_pkg;
`include "ddr_subsys_regs.svh"

   // ========================================================================
   // calibration block control bundle
   typedef struct packed {
      logic                 code_trim_override;
      logic                 code_freeze_override;
      logic                 calibration_rerun;
      logic [`CODE_W-1:0]   pulldown_override_code;
      logic [`CODE_W-1:0]   pullup_override_code;
   } calib_ctrl_t;

   typedef logic [`EV_W-1:0] event_vec_t;
   typedef logic [`IN_W-1:0] raw_in_t;
endpackage

// File: ddr_subsys_ctrl_regs_checker.sv
// port assertions for the memory subsystem register bank
// assumes it is bound into the bank; one pclk domain
`timescale 1ns/1ps
`include "ddr_subsys_regs.svh"
module ddr_subsys_ctrl_regs_checker
   import ddr_subsys_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        pclken,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [ADDR_W-1:0]           paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        memctl_reset_hold,
   input wire logic                        bus_if_reset_hold,
   input wire ddr_subsys_pkg::calib_ctrl_t calib_ctrl,
   input wire logic                        fabric_axi_select,
   input wire logic                        auto_code_lock_enable,
   input wire logic                        subsys_irq
);
   logic       wr;
   logic [4:0] off;
   // ==========
   // accepted write helper
   assign wr  = psel && penable && pready && pwrite && pclken && !pslverr;
   assign off = paddr[4:0];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========
   // assertions
   mem_hold_a: assert property (wr && off == `OFF_SOFT_RESET |=>
      memctl_reset_hold == $past(pwdata[0])) else $error("memctl hold not written");
   bus_hold_a: assert property (wr && off == `OFF_SOFT_RESET |=>
      bus_if_reset_hold == $past(pwdata[1])) else $error("bus hold not written");
   trim_wr_a: assert property (wr && off == `OFF_IO_CALIB |=>
      calib_ctrl.code_trim_override == $past(pwdata[14])) else $error("trim bad");
   freeze_wr_a: assert property (wr && off == `OFF_IO_CALIB |=>
      calib_ctrl.code_freeze_override == $past(pwdata[13])) else $error("freeze bad");
   rerun_pulse_a: assert property (wr && off == `OFF_IO_CALIB && pwdata[12] |=>
      calib_ctrl.calibration_rerun ##1 !calib_ctrl.calibration_rerun) else $error("rerun bad");
   code_wr_a: assert property (wr && off == `OFF_IO_CALIB |=>
      {calib_ctrl.pulldown_override_code, calib_ctrl.pullup_override_code}
      == $past(pwdata[11:0])) else $error("codes bad");
   proto_wr_a: assert property (wr && off == `OFF_PROTOCOL_SEL |=>
      fabric_axi_select == $past(pwdata[0])) else $error("protocol bad");
   lock_wr_a: assert property (wr && off == `OFF_AUTO_LOCK |=>
      auto_code_lock_enable == $past(pwdata[0])) else $error("auto lock bad");
   irq_masked_a: assert property (wr && off == `OFF_IRQ_MASK && pwdata[6:0] == 7'h00
      |=> ##1 !subsys_irq [*2]) else $error("irq with masks clear");
   mask_rsvd_a: assert property (pready && !pwrite && off == `OFF_IRQ_MASK |->
      prdata[31:7] == 25'h0) else $error("mask reserved bits set");
   access_a: assert property (psel && !penable && pclken |=> pready ##1 !pready)
      else $error("access cycle bad");
   cover property (wr && off == `OFF_IO_CALIB);
   cover property ($rose(subsys_irq));
   cover property (pready && pslverr);
endmodule

bind ddr_subsys_ctrl_regs ddr_subsys_ctrl_regs_checker #(.ADDR_W(ADDR_W)) chk_u (
   .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .memctl_reset_hold(memctl_reset_hold),
   .bus_if_reset_hold(bus_if_reset_hold), .calib_ctrl(calib_ctrl),
   .fabric_axi_select(fabric_axi_select), .auto_code_lock_enable(auto_code_lock_enable),
   .subsys_irq(subsys_irq));

// File: ddr_subsys_ctrl_regs_tb.sv
// self-checking bench for the memory subsystem register bank
// assumes design, package, header and checker compiled alongside
`timescale 1ns/1ps
`include "ddr_subsys_regs.svh"
module ddr_subsys_ctrl_regs_tb;
   import ddr_subsys_pkg::*;
   logic        pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  nv_pd, nv_pu;
   logic        nv_load, sub_lk, fab_lk, cal_ev, ecc_ev, bus_ev;
   logic        mem_hold, bus_hold, axi_sel, auto_lk, irq;
   calib_ctrl_t calib_ctrl;
   int          errors, checked;
   ddr_subsys_ctrl_regs dut_u (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nv_code_load(nv_load), .nv_pulldown_code(nv_pd),
      .nv_pullup_code(nv_pu), .subsystem_pll_locked(sub_lk), .fabric_pll_locked(fab_lk),
      .calibration_done_irq(cal_ev), .ecc_error_event(ecc_ev), .bus_if_event(bus_ev),
      .memctl_reset_hold(mem_hold), .bus_if_reset_hold(bus_hold), .calib_ctrl(calib_ctrl),
      .fabric_axi_select(axi_sel), .auto_code_lock_enable(auto_lk), .subsys_irq(irq));
   // ==========
   // shared tasks
   task automatic complete_run();
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         errors++;
         complete_run();
      end
      #1;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      chk("holds", 32'h0000_0003, {30'h0, bus_hold, mem_hold});
      chk("calib out", 32'h0000_0000, {17'h0, calib_ctrl});
      rdc("soft reset", `OFF_SOFT_RESET, 32'h0000_0003);
      rdc("calib", `OFF_IO_CALIB, 32'h0000_0000);
      rdc("mask", `OFF_IRQ_MASK, 32'h0000_0000);
      rdc("protocol", `OFF_PROTOCOL_SEL, 32'h0000_0000);
      rdc("auto lock", `OFF_AUTO_LOCK, 32'h0000_0000);
      rdc("fab pll", `OFF_FAB_PLL_STATUS, 32'h0000_0000);
   endtask
   task automatic t_soft_reset();
      xfer(1'b1, `OFF_SOFT_RESET, 32'hFFFF_FFFE);
      chk("holds", 32'h0000_0002, {30'h0, bus_hold, mem_hold});
      rdc("soft reset", `OFF_SOFT_RESET, 32'h0000_0002);
      xfer(1'b1, `OFF_SOFT_RESET, 32'h0000_0001);
      chk("holds", 32'h0000_0001, {30'h0, bus_hold, mem_hold});
   endtask
   task automatic t_calib();
      xfer(1'b1, `OFF_IO_CALIB, 32'hFFFF_FFFF);
      chk("calib out", 32'h0000_6FFF, {17'h0, calib_ctrl} & 32'h0000_6FFF);
      rdc("calib", `OFF_IO_CALIB, 32'h0000_6FFF);
      @(posedge pclk);
      nv_pd <= 6'h15;
      nv_pu <= 6'h2A;
      nv_load <= 1'b1;
      @(posedge pclk);
      nv_load <= 1'b0;
      rdc("nv codes", `OFF_IO_CALIB, 32'h0000_656A);
      xfer(1'b1, `OFF_IO_CALIB, 32'h0000_0000);
   endtask
   task automatic t_modes();
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, `OFF_IRQ_MASK, 32'hFFFF_FF80 | (32'h1 << i));
         rdc("mask", `OFF_IRQ_MASK, 32'h1 << i);
      end
      xfer(1'b1, `OFF_IRQ_MASK, 32'h0000_0000);
      xfer(1'b1, `OFF_PROTOCOL_SEL, 32'hFFFF_FFFF);
      chk("axi select", 32'h0000_0001, {31'h0, axi_sel});
      rdc("protocol", `OFF_PROTOCOL_SEL, 32'h0000_0001);
      xfer(1'b1, `OFF_AUTO_LOCK, 32'hFFFF_FFFF);
      chk("auto lock", 32'h0000_0001, {31'h0, auto_lk});
      xfer(1'b1, `OFF_AUTO_LOCK, 32'h0000_0000);
      chk("auto lock", 32'h0000_0000, {31'h0, auto_lk});
   endtask
   // clock enable low: a pending write must neither answer nor land
   task automatic t_freeze();
      @(posedge pclk);
      pclken <= 1'b0;
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= `OFF_PROTOCOL_SEL;
      pwdata <= 32'h0000_0000;
      wait_cyc(4);
      chk("frozen ready", 32'h0000_0000, {31'h0, pready});
      chk("frozen axi", 32'h0000_0001, {31'h0, axi_sel});
      @(posedge pclk);
      pclken <= 1'b1;
      psel <= 1'b0;
      wait_cyc(2);
      chk("frozen axi", 32'h0000_0001, {31'h0, axi_sel});
   endtask
   // reset asserted mid-run returns the soft reset holds and protocol select to their reset values
   task automatic t_mid_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      wait_cyc(3);
      chk("holds", 32'h0000_0003, {30'h0, bus_hold, mem_hold});
      chk("axi select", 32'h0000_0000, {31'h0, axi_sel});
      @(posedge pclk);
      presetn <= 1'b1;
      #1;
      rdc("protocol", `OFF_PROTOCOL_SEL, 32'h0000_0000);
      rdc("soft reset", `OFF_SOFT_RESET, 32'h0000_0003);
   endtask
   task automatic t_events();
      @(posedge pclk);
      fab_lk <= 1'b1;
      wait_cyc(8);
      rdc("fab pll", `OFF_FAB_PLL_STATUS, 32'h0000_0001);
      xfer(1'b1, `OFF_FAB_PLL_STATUS, 32'h0000_0000);
      chk("ro err", 32'h0000_0000, {31'h0, err});
      xfer(1'b1, `OFF_EVENT_STATUS, 32'h0000_007F);
      @(posedge pclk);
      {sub_lk, cal_ev, ecc_ev, bus_ev} <= 4'hF;
      wait_cyc(8);
      rdc("events", `OFF_EVENT_STATUS, 32'h0000_0071);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      @(posedge pclk);
      {sub_lk, fab_lk} <= 2'b00;
      wait_cyc(8);
      rdc("events", `OFF_EVENT_STATUS, 32'h0000_007B);
      xfer(1'b1, `OFF_IRQ_MASK, 32'h0000_0020);
      wait_cyc(3);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      xfer(1'b1, `OFF_EVENT_STATUS, 32'h0000_0020);
      wait_cyc(3);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      rdc("events", `OFF_EVENT_STATUS, 32'h0000_005B);
      xfer(1'b1, `OFF_IRQ_MASK, 32'h0000_0000);
   endtask
   task automatic t_unmapped();
      xfer(1'b0, 8'h1C, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      chk("rdata", 32'h0000_0000, rd);
      xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      rdc("soft reset", `OFF_SOFT_RESET, 32'h0000_0001);
   endtask
   // ==========
   // clock, reset and main sequence
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, nv_load} = 5'h00;
      {sub_lk, fab_lk, cal_ev, ecc_ev, bus_ev} = 5'h00;
      pclken = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {nv_pd, nv_pu} = 12'h000;
      errors = 0;
      checked = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      t_reset();
      t_soft_reset();
      t_calib();
      t_modes();
      t_freeze();
      t_events();
      t_unmapped();
      t_mid_reset();
      complete_run();
   end
endmodule
